// ===== design/rbw_pkg.sv
// package: register map, field layouts and timing for the readback window and cal store
package rbw_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] win_off      = 8'h00; // error window, hex value
  localparam logic [7:0] lead_off     = 8'h04; // max step dwell, half-ms units
  localparam logic [7:0] sample_off   = 8'h08; // raw readback sample in
  localparam logic [7:0] expect_off   = 8'h0C; // expected readback value
  localparam logic [7:0] status_off   = 8'h10; // average, error, busy
  localparam logic [7:0] step_off     = 8'h14; // list step: level + dwell
  localparam logic [7:0] level_off    = 8'h18; // applied level (read)
  localparam logic [7:0] caldata_off  = 8'h1C; // cal staging value
  localparam logic [7:0] calcmd_off   = 8'h20; // cal command
  localparam logic [7:0] calread_off  = 8'h24; // cal area readback select
  localparam logic [7:0] active_off   = 8'h28; // active cal value (read)
  // ==========================================================
  // reset values and limits
  localparam logic [7:0]  win_min   = 8'h10;
  localparam logic [7:0]  win_max   = 8'h40;
  localparam logic [7:0]  win_rst   = 8'h20;
  localparam logic [7:0]  lead_rst  = 8'h50;
  localparam int          avg_n     = 16;
  localparam int          avg_shift = 4;
  // ==========================================================
  // timing: half a millisecond in clock cycles at 100 MHz
  localparam int          clk_mhz      = 100;
  localparam int          half_ms_us   = 500;
  localparam int          half_ms_cyc  = half_ms_us * clk_mhz;
  // ==========================================================
  // cal command field positions and opcodes
  localparam int          op_lsb  = 0;
  localparam int          src_lsb = 4;
  localparam int          dst_lsb = 8;
  localparam logic [3:0]  op_save = 4'h1;
  localparam logic [3:0]  op_copy = 4'h2;
  localparam logic [3:0]  op_store_compaction = 4'h3;
  localparam int          n_areas = 6;
  typedef enum logic [2:0] {
    area_active = 3'b000, area_prev = 3'b001, area_third = 3'b010,
    area_shipped = 3'b011, area_ref = 3'b100, area_orig = 3'b101
  } area_t;
  // status field positions
  localparam int          st_err_bit  = 16;
  localparam int          st_busy_bit = 17;
  localparam int          st_zero_bit = 18;
  // list step as carried from register to sequencer
  typedef struct packed {
    logic [15:0] dwell;   // half-ms units
    logic [15:0] level;
  } step_t;
  typedef enum logic [1:0] {
    seq_idle = 2'b00, seq_drive = 2'b01, seq_zero = 2'b10
  } seq_t;
endpackage : rbw_pkg

// ===== design/readback_window_cal_store.sv
// readback error window, leading dwell limiter and six-area cal store behind AXI4-Lite
`timescale 1ns/1ps
// Notes on behaviour
// R1: window accepted 16..64, two hex digits, default 32
// R2: window query returns two hex characters
// R3: readback is average of sixteen samples
// R4: error when readback outside expected plus/minus window
// R5: leading setting is max dwell, half-ms units
// R6: long step truncated, then zero volts remainder
// R7: hex 50 means 40 ms limit
// R8: zero insertion applies even to zero-volt steps
// R9: six cal areas kept in storage
// R10: copy duplicates source area into destination
// R11: active area is the applied calibration
// R12: save shifts active, previous, third; oldest lost
// R13: host never copies into reference area; the copy command here still accepts area_ref as destination
// R14: cal tables retained until store compaction
// R15: out-of-range window rejected, previous value kept
module readback_window_cal_store #(
  parameter int half_ms_cycles = rbw_pkg::half_ms_cyc  // cycles per half millisecond
) (
  input  wire logic        aclk,          // system clock, 100 MHz
  input  wire logic        aresetn,       // synchronous reset, active low
  input  wire logic [7:0]  s_axi_awaddr,  // write address
  input  wire logic        s_axi_awvalid, // write address valid
  output logic             s_axi_awready, // write address ready
  input  wire logic [31:0] s_axi_wdata,   // write data
  input  wire logic [3:0]  s_axi_wstrb,   // write byte strobes
  input  wire logic        s_axi_wvalid,  // write data valid
  output logic             s_axi_wready,  // write data ready
  output logic [1:0]       s_axi_bresp,   // write response
  output logic             s_axi_bvalid,  // write response valid
  input  wire logic        s_axi_bready,  // write response ready
  input  wire logic [7:0]  s_axi_araddr,  // read address
  input  wire logic        s_axi_arvalid, // read address valid
  output logic             s_axi_arready, // read address ready
  output logic [31:0]      s_axi_rdata,   // read data
  output logic [1:0]       s_axi_rresp,   // read response
  output logic             s_axi_rvalid,  // read data valid
  input  wire logic        s_axi_rready,  // read data ready
  output logic [15:0]      out_level,     // level driven to output programming
  output logic             readback_err,  // readback out of window
  output logic [15:0]      active_cal     // calibration applied now
);
  // ==========================================================
  // write channel capture
  logic        aw_have_reg, w_have_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  wire         aw_take = s_axi_awvalid & s_axi_awready;
  wire         w_take  = s_axi_wvalid & s_axi_wready;
  wire         wr_go   = aw_have_reg & w_have_reg & ~s_axi_bvalid;
  wire         wr_full = &w_strb_reg;
  function automatic logic is_hit(input logic [7:0] a, input logic [7:0] off);
    is_hit = (a == off);
  endfunction : is_hit
  wire wr_win   = wr_go & wr_full & is_hit(aw_addr_reg, rbw_pkg::win_off);
  wire wr_lead  = wr_go & wr_full & is_hit(aw_addr_reg, rbw_pkg::lead_off);
  wire wr_samp  = wr_go & wr_full & is_hit(aw_addr_reg, rbw_pkg::sample_off);
  wire wr_exp   = wr_go & wr_full & is_hit(aw_addr_reg, rbw_pkg::expect_off);
  wire wr_step  = wr_go & wr_full & is_hit(aw_addr_reg, rbw_pkg::step_off);
  wire wr_cdat  = wr_go & wr_full & is_hit(aw_addr_reg, rbw_pkg::caldata_off);
  wire wr_ccmd  = wr_go & wr_full & is_hit(aw_addr_reg, rbw_pkg::calcmd_off);
  wire wr_csel  = wr_go & wr_full & is_hit(aw_addr_reg, rbw_pkg::calread_off);
  wire wr_known = wr_win | wr_lead | wr_samp | wr_exp | wr_step | wr_cdat | wr_ccmd | wr_csel;

  // channel handshake: accept each channel once, answer after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      if (aw_take) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? 2'b00 : 2'b10; // partial or unmapped: slverr
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = ~aw_have_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_have_reg & ~s_axi_bvalid;

  // ==========================================================
  // error window setting
  logic [7:0] win_reg;
  wire  [7:0] win_in = w_data_reg[7:0];
  wire        win_ok = (win_in >= rbw_pkg::win_min) && (win_in <= rbw_pkg::win_max)
                       && (w_data_reg[31:8] == 24'h00_0000);
  always_ff @(posedge aclk) begin
    if (!aresetn) win_reg <= rbw_pkg::win_rst;           // [R1]
    else if (wr_win && win_ok) win_reg <= win_in;        // [R1] [R15]
  end
  // two hex characters, upper case ascii
  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction : hex_char
  wire [15:0] win_ascii = {hex_char(win_reg[7:4]), hex_char(win_reg[3:0])}; // [R2]

  // ==========================================================
  // sixteen-sample averaging and window compare
  logic [19:0] acc_reg;
  logic [3:0]  cnt_reg;
  logic [15:0] avg_reg;
  logic [15:0] exp_reg;
  logic        err_reg;
  // six areas, one word each; declared here because the compare reads the active one
  logic [15:0] cal_mem [rbw_pkg::n_areas];               // [R9] [R14]
  wire  [19:0] acc_sum = acc_reg + {4'h0, w_data_reg[15:0]};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_reg <= 20'h0_0000;
      cnt_reg <= 4'h0;
      avg_reg <= 16'h0000;
      exp_reg <= 16'h0000;
    end else begin
      if (wr_exp) exp_reg <= w_data_reg[15:0];
      if (wr_samp) begin
        cnt_reg <= cnt_reg + 4'h1;
        if (cnt_reg == 4'(rbw_pkg::avg_n - 1)) begin
          avg_reg <= acc_sum[19:rbw_pkg::avg_shift];   // [R3]
          acc_reg <= 20'h0_0000;
        end else begin
          acc_reg <= acc_sum;
        end
      end
    end
  end
  // calibration offset from the active area is applied before compare
  wire [17:0] cal_rb = {2'b00, avg_reg} + {2'b00, cal_mem[0]};
  wire [17:0] hi_lim = {2'b00, exp_reg} + {10'h000, win_reg};
  wire [17:0] lo_lim = {2'b00, exp_reg} - {10'h000, win_reg};
  wire        lo_neg = ({2'b00, exp_reg} < {10'h000, win_reg});
  wire        rb_bad = (cal_rb > hi_lim) || (!lo_neg && (cal_rb < lo_lim)); // [R4]
  always_ff @(posedge aclk) begin
    if (!aresetn) err_reg <= 1'b0;
    else err_reg <= rb_bad;                              // [R4]
  end

  // ==========================================================
  // leading dwell limiter sequencer
  logic [7:0]          lead_reg;
  rbw_pkg::step_t      step_reg;
  rbw_pkg::seq_t       seq_reg;
  logic [31:0]         tick_reg;
  logic [15:0]         units_reg;
  logic [15:0]         level_reg;
  wire                 tick = (tick_reg == 32'(half_ms_cycles - 1));
  wire                 long_step = step_reg.dwell > {8'h00, lead_reg}; // [R5]
  always_ff @(posedge aclk) begin
    if (!aresetn) lead_reg <= rbw_pkg::lead_rst;         // [R7] 0x50 x 0.5 ms = 40 ms
    else if (wr_lead) lead_reg <= w_data_reg[7:0];       // [R5]
  end
  // a new step write restarts the sequencer; no queueing of steps
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_reg   <= rbw_pkg::seq_idle;
      step_reg  <= '0;
      tick_reg  <= 32'h0000_0000;
      units_reg <= 16'h0000;
      level_reg <= 16'h0000;
    end else if (wr_step) begin
      step_reg  <= w_data_reg;
      seq_reg   <= rbw_pkg::seq_drive;
      tick_reg  <= 32'h0000_0000;
      units_reg <= 16'h0000;
      level_reg <= w_data_reg[15:0];
    end else begin
      tick_reg <= tick ? 32'h0000_0000 : tick_reg + 32'h0000_0001;
      case (seq_reg)
        rbw_pkg::seq_idle: tick_reg <= 32'h0000_0000;
        rbw_pkg::seq_drive: if (tick) begin
          units_reg <= units_reg + 16'h0001;
          if (units_reg + 16'h0001 >= step_reg.dwell) begin
            seq_reg <= rbw_pkg::seq_idle;
          end else if (long_step && units_reg + 16'h0001 >= {8'h00, lead_reg}) begin
            seq_reg   <= rbw_pkg::seq_zero;              // [R6] [R8] even if level is zero
            level_reg <= 16'h0000;                       // [R6]
          end
        end
        rbw_pkg::seq_zero: if (tick) begin
          units_reg <= units_reg + 16'h0001;
          if (units_reg + 16'h0001 >= step_reg.dwell) seq_reg <= rbw_pkg::seq_idle; // [R6]
        end
        default: seq_reg <= rbw_pkg::seq_idle;
      endcase
    end
  end

  // ==========================================================
  // six-area calibration store
  logic [15:0] cal_stage_reg;
  logic [2:0]  cal_sel_reg;
  wire  [3:0]  cmd_op  = w_data_reg[rbw_pkg::op_lsb +: 4];
  wire  [2:0]  cmd_src = w_data_reg[rbw_pkg::src_lsb +: 3];
  wire  [2:0]  cmd_dst = w_data_reg[rbw_pkg::dst_lsb +: 3];
  wire         src_ok  = cmd_src < 3'(rbw_pkg::n_areas);
  wire         dst_ok  = cmd_dst < 3'(rbw_pkg::n_areas);
  wire         do_save = wr_ccmd && cmd_op == rbw_pkg::op_save;
  wire         do_copy = wr_ccmd && cmd_op == rbw_pkg::op_copy && src_ok && dst_ok;
  wire         do_store_compaction = wr_ccmd && cmd_op == rbw_pkg::op_store_compaction;
  genvar gi;
  generate
    for (gi = 0; gi < rbw_pkg::n_areas; gi++) begin : g_area
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cal_mem[gi] <= 16'h0000;
        end else if (do_store_compaction) begin
          cal_mem[gi] <= 16'h0000;                       // [R14] compaction clears
        end else if (do_save && gi == int'(rbw_pkg::area_active)) begin
          cal_mem[gi] <= cal_stage_reg;                  // [R12]
        end else if (do_save && gi == int'(rbw_pkg::area_prev)) begin
          cal_mem[gi] <= cal_mem[rbw_pkg::area_active];  // [R12]
        end else if (do_save && gi == int'(rbw_pkg::area_third)) begin
          cal_mem[gi] <= cal_mem[rbw_pkg::area_prev];    // [R12] old third lost
        end else if (do_copy && cmd_dst == 3'(gi)) begin
          cal_mem[gi] <= cal_mem[cmd_src];               // [R10] [R13] reference not guarded
        end
      end
    end
  endgenerate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cal_stage_reg <= 16'h0000;
      cal_sel_reg   <= 3'b000;
    end else begin
      if (wr_cdat) cal_stage_reg <= w_data_reg[15:0];
      if (wr_csel && w_data_reg[2:0] < 3'(rbw_pkg::n_areas)) cal_sel_reg <= w_data_reg[2:0];
    end
  end

  // ==========================================================
  // outputs, all registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_level    <= 16'h0000;
      readback_err <= 1'b0;
      active_cal   <= 16'h0000;
    end else begin
      out_level    <= level_reg;
      readback_err <= err_reg;
      active_cal   <= cal_mem[rbw_pkg::area_active];    // [R11]
    end
  end

  // ==========================================================
  // read channel: one-cycle answer
  wire [7:0]  ra = s_axi_araddr;
  wire [31:0] status_word = {13'h0000, seq_reg == rbw_pkg::seq_zero,
                             seq_reg != rbw_pkg::seq_idle, err_reg, avg_reg};
  wire        rd_known = is_hit(ra, rbw_pkg::win_off) | is_hit(ra, rbw_pkg::lead_off)
                       | is_hit(ra, rbw_pkg::sample_off) | is_hit(ra, rbw_pkg::expect_off)
                       | is_hit(ra, rbw_pkg::status_off) | is_hit(ra, rbw_pkg::step_off)
                       | is_hit(ra, rbw_pkg::level_off) | is_hit(ra, rbw_pkg::caldata_off)
                       | is_hit(ra, rbw_pkg::calcmd_off) | is_hit(ra, rbw_pkg::calread_off)
                       | is_hit(ra, rbw_pkg::active_off);
  wire [31:0] rd_word =
      is_hit(ra, rbw_pkg::win_off)     ? {16'h0000, win_ascii} :
      is_hit(ra, rbw_pkg::lead_off)    ? {24'h00_0000, lead_reg} :
      is_hit(ra, rbw_pkg::expect_off)  ? {16'h0000, exp_reg} :
      is_hit(ra, rbw_pkg::status_off)  ? status_word :
      is_hit(ra, rbw_pkg::step_off)    ? step_reg :
      is_hit(ra, rbw_pkg::level_off)   ? {16'h0000, level_reg} :
      is_hit(ra, rbw_pkg::caldata_off) ? {16'h0000, cal_stage_reg} :
      is_hit(ra, rbw_pkg::calread_off) ? {13'h0000, cal_sel_reg, cal_mem[cal_sel_reg]} :
      is_hit(ra, rbw_pkg::active_off)  ? {16'h0000, cal_mem[0]} : 32'h0000_0000;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_known ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = ~s_axi_rvalid;
endmodule : readback_window_cal_store

// ===== test/rbw_host.sv
// host model: AXI4-Lite master issuing command writes and queries
`timescale 1ns/1ps
module rbw_host (
  input  wire logic        aclk,                  // clock
  input  wire logic        s_axi_awready,         // aw taken
  input  wire logic        s_axi_wready,          // w taken
  input  wire logic [1:0]  s_axi_bresp,           // write status
  input  wire logic        s_axi_bvalid,          // write answer
  input  wire logic        s_axi_arready,         // ar taken
  input  wire logic [31:0] s_axi_rdata,           // read data
  input  wire logic [1:0]  s_axi_rresp,           // read status
  input  wire logic        s_axi_rvalid,          // read answer
  output logic [7:0]       s_axi_awaddr  = 8'h00, // write address
  output logic             s_axi_awvalid = 1'b0,  // aw offer
  output logic [31:0]      s_axi_wdata   = 32'h0, // write data
  output logic             s_axi_wvalid  = 1'b0,  // w offer
  output logic             s_axi_bready  = 1'b0,  // accept answer
  output logic [7:0]       s_axi_araddr  = 8'h00, // read address
  output logic             s_axi_arvalid = 1'b0,  // ar offer
  output logic             s_axi_rready  = 1'b0   // accept data
);
  // ==========================================================
  // write: aw and w offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        return;
      end
    end
    readback_window_cal_store_tb.hang();
  endtask : wr
  // ==========================================================
  // read: rready held until the answer is sampled
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        return;
      end
    end
    readback_window_cal_store_tb.hang();
  endtask : rd
endmodule : rbw_host

// ===== test/rbw_asserts.sv
// checker: bus handshakes and output causes of the readback window block
`timescale 1ns/1ps
module rbw_asserts #(
  parameter int half_ms_cycles = 4 // cycles per half ms
) (
  input wire logic        aclk,          // clock
  input wire logic        aresetn,       // sync reset, low
  input wire logic        s_axi_awvalid, // aw offer
  input wire logic        s_axi_awready, // aw taken
  input wire logic        s_axi_wvalid,  // w offer
  input wire logic        s_axi_wready,  // w taken
  input wire logic [1:0]  s_axi_bresp,   // write status
  input wire logic        s_axi_bvalid,  // write answer
  input wire logic        s_axi_bready,  // answer accepted
  input wire logic        s_axi_arvalid, // ar offer
  input wire logic        s_axi_arready, // ar taken
  input wire logic [31:0] s_axi_rdata,   // read data
  input wire logic [1:0]  s_axi_rresp,   // read status
  input wire logic        s_axi_rvalid,  // read answer
  input wire logic        s_axi_rready,  // data accepted
  input wire logic [15:0] out_level,     // driven level
  input wire logic        readback_err,  // window flag
  input wire logic [15:0] active_cal     // applied cal
);
  logic [3:0] since_b; // cycles since a write answer or reset
  // write-answer age, saturating; reset counts as a cause too
  always_ff @(posedge aclk) begin
    if (!aresetn || s_axi_bvalid) since_b <= 4'h0;
    else if (since_b != 4'hF) since_b <= since_b + 4'h1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_aw_taken; s_axi_awvalid && s_axi_awready; endsequence
  sequence s_w_taken;  s_axi_wvalid && s_axi_wready;   endsequence
  sequence s_ar_taken; s_axi_arvalid && s_axi_arready; endsequence
  // ==========================================================
  // handshake timing
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped early");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer changed early");
  a_write_answer: assert property (s_aw_taken ##0 s_w_taken |=> ##1 s_axi_bvalid) else $error("write answer late");
  a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid) else $error("read answer late");
  a_write_cause: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_wvalid && s_axi_wready, 2) || $past(s_axi_awvalid && s_axi_awready, 2)) else $error("write answer without request");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while answering");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while answering");
  // ==========================================================
  // outputs and their causes
  a_reset_outs: assert property (disable iff (1'b0) !aresetn |=> out_level == 16'h0 && !readback_err && active_cal == 16'h0 && s_axi_awready && s_axi_arready) else $error("reset state wrong");
  a_cal_quiet: assert property ($changed(active_cal) |-> since_b <= 4'h3) else $error("cal changed without command");
  a_err_quiet: assert property ($changed(readback_err) |-> since_b <= 4'h4) else $error("error flag changed without cause");
endmodule : rbw_asserts
bind readback_window_cal_store rbw_asserts #(.half_ms_cycles(half_ms_cycles)) chk_u (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .out_level,
  .readback_err, .active_cal
);

// ===== test/readback_window_cal_store_tb.sv
// testbench: command sequences against the readback window and cal store block
`timescale 1ns/1ps
module readback_window_cal_store_tb;
  localparam int hc = 4; // short half-ms keeps dwell runs brief
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] out_level, active_cal;
  logic        readback_err;
  int          n_errors = 0, n_checks = 0;
  logic [7:0]  win_in[5] = '{8'h10, 8'h40, 8'h0F, 8'h41, 8'h20};
  logic [15:0] win_rb[5] = '{16'h3130, 16'h3430, 16'h3430, 16'h3430, 16'h3230};
  logic [15:0] exp_in[5] = '{16'h006B, 16'h007B, 16'h007C, 16'h005B, 16'h005A};
  logic        err_ex[5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  logic [15:0] area_ex[6] = '{16'h3, 16'h3, 16'h2, 16'h3, 16'h0, 16'h0};
  readback_window_cal_store #(.half_ms_cycles(hc)) DUT (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .out_level, .readback_err, .active_cal
  );
  rbw_host host (
    .aclk, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_wdata, .s_axi_wvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_rready
  );
  // 100 MHz clock
  always #5 aclk = ~aclk;
  // ==========================================================
  // compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] ex, input string what);
    n_checks++;
    if (got !== ex) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, ex);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [31:0] ex, input string what);
    host.rd(a, rd_v, rsp);
    chk(rd_v, ex, what);
  endtask : rchk
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  task automatic hang();
    n_errors++;
    $display("wrong value at %0t: bus answer never came", $time);
    test_done();
  endtask : hang
  // ==========================================================
  // cal store and dwell helpers
  task automatic cal_cmd(input logic [3:0] op, input logic [2:0] s, input logic [2:0] d);
    host.wr(rbw_pkg::calcmd_off, {21'h0, d, 1'b0, s, op}, rsp);
  endtask : cal_cmd
  task automatic area_chk(input logic [2:0] ar, input logic [15:0] v);
    host.wr(rbw_pkg::calread_off, {29'h0, ar}, rsp);
    rchk(rbw_pkg::calread_off, {13'h0, ar, v}, "cal area");
  endtask : area_chk
  // n: cycles at level within a fixed 400-cycle window, fin: level left behind
  task automatic step(input logic [15:0] lv, input logic [15:0] dw, input int n,
                      input logic [15:0] fin);
    int cnt;
    cnt = 0;
    host.wr(rbw_pkg::step_off, {dw, lv}, rsp);
    // counted here, not in a side process, so the clear cannot race a count
    repeat (400) begin
      @(posedge aclk);
      if (out_level === lv) cnt++;
    end
    chk(32'(cnt), 32'(n), "dwell cycles");
    chk({16'h0, out_level}, {16'h0, fin}, "final level");
    host.rd(rbw_pkg::status_off, rd_v, rsp);
    chk({31'h0, rd_v[rbw_pkg::st_busy_bit]}, 32'h0, "step finished");
  endtask : step
  // ==========================================================
  // main sequence
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(rbw_pkg::win_off, 32'h0000_3230, "window default");
    rchk(rbw_pkg::lead_off, 32'h0000_0050, "leading default");
    foreach (win_in[i]) begin
      host.wr(rbw_pkg::win_off, {24'h0, win_in[i]}, rsp);
      rchk(rbw_pkg::win_off, {16'h0, win_rb[i]}, "window echo");
    end
    host.wr(8'h3C, 32'h1, rsp);
    chk({30'h0, rsp}, 32'h2, "unmapped write");
    host.rd(8'h3C, rd_v, rsp);
    chk({30'h0, rsp}, 32'h2, "unmapped read");
    for (int i = 0; i < 16; i++) host.wr(rbw_pkg::sample_off, 32'(100 + i), rsp);
    host.rd(rbw_pkg::status_off, rd_v, rsp);
    chk({16'h0, rd_v[15:0]}, 32'h6B, "average");
    host.wr(rbw_pkg::win_off, 32'h10, rsp);
    foreach (exp_in[i]) begin
      host.wr(rbw_pkg::expect_off, {16'h0, exp_in[i]}, rsp);
      repeat (3) @(posedge aclk);
      chk({31'h0, readback_err}, {31'h0, err_ex[i]}, "error flag");
    end
    for (int i = 1; i < 5; i++) begin
      host.wr(rbw_pkg::caldata_off, 32'(i), rsp);
      cal_cmd(rbw_pkg::op_save, 3'h0, 3'h0);
    end
    @(posedge aclk);
    chk({16'h0, active_cal}, 32'h4, "active after saves");
    area_chk(rbw_pkg::area_third, 16'h2);
    cal_cmd(rbw_pkg::op_copy, rbw_pkg::area_prev, rbw_pkg::area_shipped);
    cal_cmd(rbw_pkg::op_copy, rbw_pkg::area_shipped, rbw_pkg::area_active);
    rchk(rbw_pkg::active_off, 32'h3, "active after copy");
    foreach (area_ex[i]) area_chk(3'(i), area_ex[i]);
    cal_cmd(rbw_pkg::op_store_compaction, 3'h0, 3'h0);
    foreach (area_ex[i]) area_chk(3'(i), 16'h0);
    step(16'h0ABC, 16'h0051, 16'h50 * hc, 16'h0);
    host.wr(rbw_pkg::lead_off, 32'h2, rsp);
    step(16'h1234, 16'h0002, 400, 16'h1234);
    step(16'h0567, 16'h0005, 2 * hc, 16'h0);
    host.wr(rbw_pkg::step_off, {16'h0005, 16'h0000}, rsp);
    repeat (10) @(posedge aclk);
    host.rd(rbw_pkg::status_off, rd_v, rsp);
    chk({31'h0, rd_v[rbw_pkg::st_zero_bit]}, 32'h1, "zero phase");
    test_done();
  end
endmodule : readback_window_cal_store_tb
